// *** design/ccd_core.sv ***
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "ccd_regs.svh"
module ccd_core
#(
   parameter int BANK_W          = 1,
   parameter int STACK_DEPTH     = 16,
   parameter int WDOG_PRESCALE_W = 8
)
(
   // Clock and reset.
   input  wire logic        CLK_IN,
   input  wire logic        RESET_N_IN,
   // AHB-Lite slave.
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output logic [31:0]      HRDATA_OUT,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   // Core state.
   output logic [14:0]      PC_OUT
);
   localparam int IDX_W   = BANK_W + `CCD_FADDR_W;
   localparam int FILE_N  = 1 << IDX_W;
   localparam int PTR_W   = $clog2(STACK_DEPTH);

   generate
      if (BANK_W < 1 || BANK_W > 3)
      begin : g_bank_check
         $error("BANK_W must lie between 1 and 3");
      end
      if (STACK_DEPTH < 2 || PTR_W > 16 || (1 << PTR_W) != STACK_DEPTH)
      begin : g_stack_check
         $error("STACK_DEPTH must be a power of two from 2 to 65536");
      end
      if (WDOG_PRESCALE_W < 1 || WDOG_PRESCALE_W > 16)
      begin : g_wdog_check
         $error("WDOG_PRESCALE_W must lie between 1 and 16");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State declarations.
   ccd_pkg::ccd_exec_state_type  exec_state_q;
   logic [7:0]                   accum_q;
   logic                         zero_q;
   logic                         expiry_q;
   logic                         sleep_q;
   logic                         skip_q;
   logic [`CCD_PC_W-1:0]         pc_q;
   logic [`CCD_PCHI_W-1:0]       pchi_q;
   logic [BANK_W-1:0]            bank_q;
   logic [`CCD_WDOG_W-1:0]       wdog_q;
   logic [WDOG_PRESCALE_W-1:0]   presc_q;
   logic [PTR_W-1:0]             sp_q;
   logic [`CCD_PC_W-1:0]         stack_q [STACK_DEPTH];
   logic [7:0]                   file_q [FILE_N];
   logic                         dp_valid_q;
   logic                         dp_write_q;
   logic [`CCD_DEC_W-1:0]        dp_addr_q;
   logic [31:0]                  hrdata_q;
   logic                         hready_q;
   logic                         hresp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus address and data phase tracking.
   logic addr_take;
   logic wr_fire;
   logic wr_file;
   logic wr_instr;
   logic wr_accum;
   logic wr_status;
   logic wr_pc;
   logic wr_pchi;
   logic wr_bank;

   assign addr_take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
   assign wr_fire   = dp_valid_q & dp_write_q & hready_q;
   assign wr_file   = wr_fire & dp_addr_q[`CCD_FILE_SEL_BIT];
   assign wr_instr  = wr_fire & (dp_addr_q == `CCD_OFS_INSTR);
   assign wr_accum  = wr_fire & (dp_addr_q == `CCD_OFS_ACCUM);
   assign wr_status = wr_fire & (dp_addr_q == `CCD_OFS_STATUS);
   assign wr_pc     = wr_fire & (dp_addr_q == `CCD_OFS_PC);
   assign wr_pchi   = wr_fire & (dp_addr_q == `CCD_OFS_PCHI);
   assign wr_bank   = wr_fire & (dp_addr_q == `CCD_OFS_BANK);

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q  <= '0;
      end
      else if (HREADY_IN)
      begin
         dp_valid_q <= addr_take;
         dp_write_q <= HWRITE_IN;
         dp_addr_q  <= HADDR_IN[`CCD_DEC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction decode and execution.
   logic [`CCD_INSTR_W-1:0] instr;
   logic [IDX_W-1:0]        exec_idx;
   logic [7:0]              operand;
   logic [7:0]              alu_result;
   logic                    alu_acc_we;
   logic                    alu_file_we;
   logic                    alu_zero_we;
   logic                    alu_zero_val;
   logic                    alu_skip;
   logic                    alu_call_acc;
   logic                    alu_wdclr;
   logic                    alu_two_cycle;
   logic                    exec_go;
   logic [`CCD_PC_W-1:0]    pc_next;

   assign instr    = HWDATA_IN[`CCD_INSTR_W-1:0];
   assign exec_idx = {bank_q, instr[`CCD_FADDR_W-1:0]};
   assign operand  = file_q[exec_idx];
   assign exec_go  = wr_instr & ~skip_q;
   assign pc_next  = pc_q + 15'h0001;

   ccd_alu u_alu
   (
      .instr_in      (instr),
      .operand_in    (operand),
      .result_out    (alu_result),
      .acc_we_out    (alu_acc_we),
      .file_we_out   (alu_file_we),
      .zero_we_out   (alu_zero_we),
      .zero_val_out  (alu_zero_val),
      .skip_out      (alu_skip),
      .call_acc_out  (alu_call_acc),
      .wdclr_out     (alu_wdclr),
      .two_cycle_out (alu_two_cycle)
   );

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         exec_state_q <= ccd_pkg::CCD_EXEC_IDLE;
         hready_q     <= 1'b1;
      end
      else
      begin
         unique case (exec_state_q)
            ccd_pkg::CCD_EXEC_IDLE:
            begin
               if (exec_go & alu_two_cycle)
               begin
                  exec_state_q <= ccd_pkg::CCD_EXEC_SECOND;
               end
            end
            ccd_pkg::CCD_EXEC_SECOND:
            begin
               exec_state_q <= ccd_pkg::CCD_EXEC_IDLE;
            end
         endcase
         hready_q <= ~(exec_go & alu_two_cycle);
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         skip_q <= 1'b0;
      end
      else if (exec_go & alu_skip)
      begin
         skip_q <= 1'b1;
      end
      else if (wr_instr)
      begin
         skip_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         accum_q <= `CCD_ZERO_BYTE;
      end
      else if (exec_go & alu_acc_we)
      begin
         accum_q <= alu_result;
      end
      else if (wr_accum)
      begin
         accum_q <= HWDATA_IN[7:0];
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         zero_q   <= 1'b0;
         expiry_q <= `CCD_FLAG_RESET;
         sleep_q  <= `CCD_FLAG_RESET;
      end
      else if (exec_go)
      begin
         if (alu_zero_we)
         begin
            zero_q <= alu_zero_val;
         end
         if (alu_wdclr)
         begin
            expiry_q <= 1'b1;
            sleep_q  <= 1'b1;
         end
      end
      else if (wr_status)
      begin
         zero_q   <= HWDATA_IN[`CCD_ST_ZERO];
         expiry_q <= HWDATA_IN[`CCD_ST_EXPIRY];
         sleep_q  <= HWDATA_IN[`CCD_ST_SLEEP];
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pc_q <= `CCD_PC_RESET;
      end
      else if (exec_go & alu_call_acc)
      begin
         pc_q <= {pchi_q, accum_q};
      end
      else if (wr_instr)
      begin
         pc_q <= pc_next;
      end
      else if (wr_pc)
      begin
         pc_q <= HWDATA_IN[`CCD_PC_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pchi_q <= '0;
         bank_q <= '0;
      end
      else
      begin
         if (wr_pchi)
         begin
            pchi_q <= HWDATA_IN[`CCD_PCHI_W-1:0];
         end
         if (wr_bank)
         begin
            bank_q <= HWDATA_IN[BANK_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog counter and prescaler.
   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wdog_q  <= `CCD_WDOG_CLEAR;
         presc_q <= '0;
      end
      else if (exec_go & alu_wdclr)
      begin
         wdog_q  <= `CCD_WDOG_CLEAR;
         presc_q <= '0;
      end
      else
      begin
         presc_q <= presc_q + 1'b1;
         if ((&presc_q) && (wdog_q != `CCD_WDOG_MAX))
         begin
            wdog_q <= wdog_q + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Return stack and file registers, one flip-flop group per entry.
   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sp_q <= '0;
      end
      else if (exec_go & alu_call_acc)
      begin
         sp_q <= sp_q + 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < STACK_DEPTH; gi++)
      begin : g_stack
         always_ff @(posedge CLK_IN or negedge rst_n_q)
         begin
            if (!rst_n_q)
            begin
               stack_q[gi] <= `CCD_PC_RESET;
            end
            else if (exec_go & alu_call_acc & (sp_q == PTR_W'(gi)))
            begin
               stack_q[gi] <= pc_next;
            end
         end
      end
      for (gi = 0; gi < FILE_N; gi++)
      begin : g_file
         always_ff @(posedge CLK_IN or negedge rst_n_q)
         begin
            if (!rst_n_q)
            begin
               file_q[gi] <= `CCD_ZERO_BYTE;
            end
            else if (exec_go & alu_file_we & (exec_idx == IDX_W'(gi)))
            begin
               file_q[gi] <= alu_result;
            end
            else if (wr_file & (dp_addr_q[IDX_W+1:2] == IDX_W'(gi)))
            begin
               file_q[gi] <= HWDATA_IN[7:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the address phase.
   logic [31:0]             rd_d;
   logic [`CCD_DEC_W-1:0]   rd_addr;
   logic [PTR_W-1:0]        sp_top;

   assign rd_addr = HADDR_IN[`CCD_DEC_W-1:0];
   assign sp_top  = sp_q - 1'b1;

   always_comb
   begin
      rd_d = 32'h00000000;
      if (rd_addr[`CCD_FILE_SEL_BIT])
      begin
         rd_d[7:0] = file_q[rd_addr[IDX_W+1:2]];
      end
      else
      begin
         unique case (rd_addr)
            `CCD_OFS_ACCUM:  rd_d[7:0] = accum_q;
            `CCD_OFS_STATUS:
            begin
               rd_d[`CCD_ST_ZERO]   = zero_q;
               rd_d[`CCD_ST_EXPIRY] = expiry_q;
               rd_d[`CCD_ST_SLEEP]  = sleep_q;
               rd_d[`CCD_ST_SKIP]   = skip_q;
               rd_d[`CCD_ST_BUSY]   = (exec_state_q == ccd_pkg::CCD_EXEC_SECOND);
            end
            `CCD_OFS_PC:     rd_d[`CCD_PC_W-1:0] = pc_q;
            `CCD_OFS_PCHI:   rd_d[`CCD_PCHI_W-1:0] = pchi_q;
            `CCD_OFS_BANK:   rd_d[BANK_W-1:0] = bank_q;
            `CCD_OFS_WDOG:
            begin
               rd_d[`CCD_WDOG_W-1:0] = wdog_q;
               rd_d[16 +: WDOG_PRESCALE_W] = presc_q;
            end
            `CCD_OFS_STACK:
            begin
               rd_d[`CCD_PC_W-1:0] = stack_q[sp_top];
               rd_d[16 +: PTR_W]   = sp_q;
            end
            default:         rd_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         hrdata_q <= 32'h00000000;
         hresp_q  <= 1'b0;
      end
      else
      begin
         hresp_q <= 1'b0;
         if (addr_take & ~HWRITE_IN)
         begin
            hrdata_q <= rd_d;
         end
      end
   end

   assign HRDATA_OUT    = hrdata_q;
   assign HREADYOUT_OUT = hready_q;
   assign HRESP_OUT     = hresp_q;
   assign PC_OUT        = pc_q;
endmodule // ccd_core

// *** design/ccd_regs.svh ***
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
// What this block does
// - Watchdog clear zeroes the watchdog counter.
// - Watchdog clear zeroes prescaler, sets both flags.
// - Accumulator call pushes return address first.
// - Accumulator call loads PC from accumulator, latch.
// - Accumulator call takes two cycles, flags kept.
// - Complement file inverts, d picks destination, zero.
// - Clear file writes zero, sets zero flag.
// - Decrement file subtracts one, d picks destination.
// - Clear accumulator loads zero, sets zero flag.
// - Decrement skip keeps flags, zero discards next.
// - A taken skip costs two instruction cycles.

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the bus.
`define CCD_DEC_W          13
`define CCD_OFS_INSTR      13'h0000
`define CCD_OFS_ACCUM      13'h0004
`define CCD_OFS_STATUS     13'h0008
`define CCD_OFS_PC         13'h000c
`define CCD_OFS_PCHI       13'h0010
`define CCD_OFS_BANK       13'h0014
`define CCD_OFS_WDOG       13'h0018
`define CCD_OFS_STACK      13'h001c
`define CCD_FILE_SEL_BIT   12

////////////////////////////////////////////////////////////////////////////////
// Status register bit positions.
`define CCD_ST_ZERO        0
`define CCD_ST_EXPIRY      1
`define CCD_ST_SLEEP       2
`define CCD_ST_SKIP        3
`define CCD_ST_BUSY        4

////////////////////////////////////////////////////////////////////////////////
// Instruction word layout and operation codes.
`define CCD_INSTR_W        14
`define CCD_OP_MSB         13
`define CCD_OP_LSB         8
`define CCD_DEST_BIT       7
`define CCD_FADDR_W        7
`define CCD_OP_NOP         6'h00
`define CCD_OP_WDCLR       6'h01
`define CCD_OP_CALL_ACC    6'h02
`define CCD_OP_COMP_FILE   6'h03
`define CCD_OP_CLR_FILE    6'h04
`define CCD_OP_DEC_FILE    6'h05
`define CCD_OP_CLR_ACC     6'h06
`define CCD_OP_DEC_SKIP    6'h07

////////////////////////////////////////////////////////////////////////////////
// Widths and reset values.
`define CCD_PC_W           15
`define CCD_PCHI_W         7
`define CCD_WDOG_W         8
`define CCD_ZERO_BYTE      8'h00
`define CCD_PC_RESET       15'h0000
`define CCD_FLAG_RESET     1'b1
`define CCD_WDOG_CLEAR     8'h00
`define CCD_WDOG_MAX       8'hff
`endif

// *** design/ccd_pkg.sv ***
package ccd_pkg;
   typedef enum logic {CCD_EXEC_IDLE, CCD_EXEC_SECOND} ccd_exec_state_type;
endpackage

// *** design/ccd_alu.sv ***
`timescale 1ns/10ps
`include "ccd_regs.svh"
module ccd_alu
(
   // Instruction and operands.
   input  wire logic [`CCD_INSTR_W-1:0] instr_in,
   input  wire logic [7:0]              operand_in,
   // Decoded effects.
   output logic [7:0]                   result_out,
   output logic                         acc_we_out,
   output logic                         file_we_out,
   output logic                         zero_we_out,
   output logic                         zero_val_out,
   output logic                         skip_out,
   output logic                         call_acc_out,
   output logic                         wdclr_out,
   output logic                         two_cycle_out
);
   logic [5:0] op;
   logic       dest;
   logic [7:0] dec_val;

   assign op      = instr_in[`CCD_OP_MSB:`CCD_OP_LSB];
   assign dest    = instr_in[`CCD_DEST_BIT];
   assign dec_val = operand_in - 8'h01;

   always_comb
   begin
      result_out    = `CCD_ZERO_BYTE;
      acc_we_out    = 1'b0;
      file_we_out   = 1'b0;
      zero_we_out   = 1'b0;
      zero_val_out  = 1'b0;
      skip_out      = 1'b0;
      call_acc_out  = 1'b0;
      wdclr_out     = 1'b0;
      two_cycle_out = 1'b0;
      unique case (op)
         `CCD_OP_WDCLR:
         begin
            wdclr_out = 1'b1;
         end
         `CCD_OP_CALL_ACC:
         begin
            call_acc_out  = 1'b1;
            two_cycle_out = 1'b1;
         end
         `CCD_OP_COMP_FILE:
         begin
            result_out   = ~operand_in;
            acc_we_out   = ~dest;
            file_we_out  = dest;
            zero_we_out  = 1'b1;
            zero_val_out = (~operand_in == `CCD_ZERO_BYTE);
         end
         `CCD_OP_CLR_FILE:
         begin
            result_out   = `CCD_ZERO_BYTE;
            file_we_out  = 1'b1;
            zero_we_out  = 1'b1;
            zero_val_out = 1'b1;
         end
         `CCD_OP_DEC_FILE:
         begin
            result_out   = dec_val;
            acc_we_out   = ~dest;
            file_we_out  = dest;
            zero_we_out  = 1'b1;
            zero_val_out = (dec_val == `CCD_ZERO_BYTE);
         end
         `CCD_OP_CLR_ACC:
         begin
            result_out   = `CCD_ZERO_BYTE;
            acc_we_out   = 1'b1;
            zero_we_out  = 1'b1;
            zero_val_out = 1'b1;
         end
         `CCD_OP_DEC_SKIP:
         begin
            result_out    = dec_val;
            acc_we_out    = ~dest;
            file_we_out   = dest;
            skip_out      = (dec_val == `CCD_ZERO_BYTE);
            two_cycle_out = (dec_val == `CCD_ZERO_BYTE);
         end
         default:
         begin
            result_out = `CCD_ZERO_BYTE;
         end
      endcase
   end
endmodule // ccd_alu

// *** bench/ccd_core_asserts.sv ***
`timescale 1ns/10ps
module ccd_core_asserts
#(
   parameter int WDOG_PRESCALE_W = 8
)
(
   input wire logic        CLK_IN,
   input wire logic        RESET_N_IN,
   input wire logic        HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0]  HTRANS_IN,
   input wire logic        HWRITE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic        HREADY_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic        HREADYOUT_OUT,
   input wire logic [14:0] PC_OUT
);
   localparam int AGE_MAX = 2**WDOG_PRESCALE_W - 1;
   logic        dp_q, dw_q, acc_ok_q, st_ok_q, skp_q, wd_ok_q;
   logic [12:0] da_q;
   logic [7:0]  acc_q;
   logic [6:0]  ph_q;
   logic [2:0]  st_q;
   logic [15:0] age_q;
   wire         done = dp_q & HREADY_IN;
   wire         ex   = done & dw_q & (da_q == 13'h0000);
   wire [5:0]   op   = HWDATA_IN[13:8];
   wire         rd   = HSEL_IN & HTRANS_IN[1] & HREADY_IN & !HWRITE_IN;

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the bus state and of the flags that instructions must leave.
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         dp_q     <= 1'b0;
         dw_q     <= 1'b0;
         da_q     <= 13'h0000;
         acc_q    <= 8'h00;
         ph_q     <= 7'h00;
         acc_ok_q <= 1'b1;
         st_q     <= 3'h6;
         st_ok_q  <= 1'b1;
         skp_q    <= 1'b0;
         wd_ok_q  <= 1'b0;
         age_q    <= 16'h0000;
      end
      else
      begin
         age_q <= age_q + 16'h0001;
         if (HREADY_IN)
         begin
            dp_q <= HSEL_IN & HTRANS_IN[1];
            da_q <= HADDR_IN[12:0];
            dw_q <= HWRITE_IN;
         end
         if (done & dw_q & (da_q == 13'h0004))
         begin
            acc_q    <= HWDATA_IN[7:0];
            acc_ok_q <= 1'b1;
         end
         if (done & dw_q & (da_q == 13'h0008))
         begin
            st_q    <= HWDATA_IN[2:0];
            st_ok_q <= 1'b1;
         end
         if (done & dw_q & (da_q == 13'h0010))
            ph_q <= HWDATA_IN[6:0];
         if (ex)
         begin
            skp_q <= (op == 6'h07);
            if (skp_q)
            begin
               acc_ok_q <= 1'b0;
               st_ok_q  <= 1'b0;
               wd_ok_q  <= 1'b0;
            end
            else if (op == 6'h01)
            begin
               st_q[2:1] <= 2'b11;
               age_q     <= 16'h0000;
               wd_ok_q   <= 1'b1;
            end
            else if (op == 6'h03 || op == 6'h05)
            begin
               st_ok_q <= 1'b0;
               if (!HWDATA_IN[7])
                  acc_ok_q <= 1'b0;
            end
            else if (op == 6'h07 && !HWDATA_IN[7])
               acc_ok_q <= 1'b0;
            else if (op == 6'h04)
               st_q[0] <= 1'b1;
            else if (op == 6'h06)
            begin
               acc_q    <= 8'h00;
               acc_ok_q <= 1'b1;
               st_q[0]  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   property p_call_stall;
      ex && op == 6'h02 && !skp_q |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
   endproperty
   a_call_stall: assert property (p_call_stall) else $error("call stall wrong");
   property p_call_pc;
      ex && op == 6'h02 && !skp_q && acc_ok_q |=> PC_OUT == {ph_q, acc_q};
   endproperty
   a_call_pc: assert property (p_call_pc) else $error("call target wrong");
   property p_seq_pc; ex && op != 6'h02 |=> PC_OUT == $past(PC_OUT) + 15'h0001; endproperty
   a_seq_pc: assert property (p_seq_pc) else $error("pc did not step by one");
   property p_stall_cause;
      $fell(HREADYOUT_OUT) |-> $past(ex && (op == 6'h02 || op == 6'h07));
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without cause");
   property p_stall_len; !HREADYOUT_OUT |=> HREADYOUT_OUT; endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall longer than one");
   property p_acc_read;
      rd && HADDR_IN[12:0] == 13'h0004 && acc_ok_q |=>
         HRDATA_OUT == {24'h000000, $past(acc_q)};
   endproperty
   a_acc_read: assert property (p_acc_read) else $error("accumulator value wrong");
   property p_status_read;
      rd && HADDR_IN[12:0] == 13'h0008 && st_ok_q |=> HRDATA_OUT[2:0] == $past(st_q);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status wrong");
   property p_wdog_read;
      rd && HADDR_IN[12:0] == 13'h0018 && wd_ok_q && age_q < AGE_MAX |=>
         HRDATA_OUT[7:0] == 8'h00 &&
         HRDATA_OUT[16+:WDOG_PRESCALE_W] == $past(age_q[WDOG_PRESCALE_W-1:0]);
   endproperty
   a_wdog_read: assert property (p_wdog_read) else $error("watchdog wrong");
   c_call: cover property (ex && op == 6'h02);
   c_skip: cover property ($fell(HREADYOUT_OUT) && $past(op == 6'h07));
   c_wdog: cover property (rd && HADDR_IN[12:0] == 13'h0018 && wd_ok_q);
endmodule // ccd_core_asserts

bind ccd_core ccd_core_asserts #(.WDOG_PRESCALE_W(WDOG_PRESCALE_W)) u_chk
(
   .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
   .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
   .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .PC_OUT(PC_OUT)
);

// *** bench/core_clear_dec_call_ops_bench.sv ***
`timescale 1ns/10ps
module core_clear_dec_call_ops_bench;
   logic        clk, rst_n, hsel, hwrite, hready, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [14:0] pc, pc0;
   int          bad_count, n_checks, cyc;

   ccd_core u_dut
   (
      .CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PC_OUT(pc)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         bad_count++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for a rising edge at which hready is high; hready and read data are both sampled at the falling edge before it.
   task wt;
      logic s;
      s = 1'b0;
      while (!s)
      begin
         @(negedge clk);
         s = hready;
         r = hrdata;
         @(posedge clk);
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= a;
      wt();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt();
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rc(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task ex(input logic [13:0] i);
      wr(32'h0, {18'h0, i});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hsel   = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      haddr  = 32'h0;
      hwdata = 32'h0;
      rst_n  = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wr(32'h4, 32'h5a);
      wr(32'h10, 32'h35);
      wr(32'hc, 32'h100);
      ex(14'h0200);
      @(negedge clk);
      chk({31'h0, hready}, 32'h0);
      rc(32'h1c, 32'h0001_0101);
      chk({17'h0, pc}, 32'h35_5a);
      rc(32'h8, 32'h6);
      wr(32'h1040, 32'h0);
      ex(14'h0390);
      rc(32'h1040, 32'hff);
      rc(32'h8, 32'h6);
      ex(14'h0310);
      rc(32'h4, 32'h0);
      rc(32'h8, 32'h7);
      wr(32'h14, 32'h1);
      wr(32'h1240, 32'h1);
      ex(14'h0590);
      rc(32'h1240, 32'h0);
      rc(32'h1040, 32'hff);
      ex(14'h0510);
      rc(32'h4, 32'hff);
      rc(32'h8, 32'h6);
      wr(32'h1240, 32'h33);
      ex(14'h0410);
      rc(32'h1240, 32'h0);
      rc(32'h8, 32'h7);
      wr(32'h8, 32'h0);
      ex(14'h0600);
      rc(32'h4, 32'h0);
      rc(32'h8, 32'h1);
      repeat (600) @(posedge clk);
      wr(32'h8, 32'h0);
      ex(14'h0100);
      rc(32'h8, 32'h6);
      xfer(1'b0, 32'h18, 32'h0);
      chk(r & 32'hff, 32'h0);
      wr(32'h1240, 32'h2);
      ex(14'h0790);
      @(negedge clk);
      chk({31'h0, hready}, 32'h1);
      rc(32'h8, 32'h6);
      ex(14'h0790);
      @(negedge clk);
      chk({31'h0, hready}, 32'h0);
      rc(32'h1240, 32'h0);
      rc(32'h8, 32'he);
      wr(32'h4, 32'h77);
      @(negedge clk);
      pc0 = pc;
      ex(14'h0600);
      rc(32'h4, 32'h77);
      chk({17'h0, pc}, {17'h0, pc0 + 15'h1});
      ex(14'h0710);
      rc(32'h4, 32'hff);
      summarize();
   end
endmodule // core_clear_dec_call_ops_bench
